// >>> common/icc_pkg.sv
/*
 * Shared constants and carrier types of the two-wire bus control tail,
 * event flag bank and serial clock generator.
 * Assumes one 200 MHz bus clock and a protocol engine on the same clock.
 */
`default_nettype none
package icc_pkg;
	//--------------------------------------------------------------
	// register map
	//--------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_DIV = 8'h08;
	localparam logic [7:0] OFF_TIME = 8'h14;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_7F0E;
	localparam logic [17:0] DIV_RESET = 18'h0_0000;
	localparam logic [3:0] GLITCH_RESET = 4'h0;
	// control bit positions
	localparam int unsigned CB_RST = 0;
	localparam int unsigned CB_EN = 1;
	localparam int unsigned CB_SCL = 2;
	localparam int unsigned CB_GC = 3;
	localparam int unsigned CB_IE_TX = 8;
	localparam int unsigned CB_IE_RX = 9;
	localparam int unsigned CB_IE_NACK = 10;
	localparam int unsigned CB_IE_STOP = 11;
	localparam int unsigned CB_IE_ADDR = 12;
	localparam int unsigned CB_IE_ARB = 13;
	localparam int unsigned CB_IE_START = 14;
	// status bit positions
	localparam int unsigned SB_DFLT = 20;
	localparam int unsigned SB_START = 11;
	localparam int unsigned SB_ARB = 10;
	localparam int unsigned SB_GCALL = 9;
	localparam int unsigned SB_OWN = 8;
	localparam int unsigned SB_STOP = 7;
	localparam int unsigned SB_NACK = 6;
	localparam int unsigned SB_RX = 5;
	localparam int unsigned SB_TX = 4;
	localparam int unsigned SB_FOREIGN = 3;
	localparam int unsigned SB_ACTIVE = 2;
	localparam int unsigned SB_NACK_LVL = 1;
	localparam int unsigned SB_DIR = 0;
	// divider and timing fields
	localparam int unsigned DIV_W = 18;
	localparam int unsigned GLITCH_LSB = 10;
	localparam int unsigned GLITCH_W = 4;
	localparam int unsigned SOFT_RST_CYCLES = 2;
	//--------------------------------------------------------------
	// carrier types
	//--------------------------------------------------------------
	// one-cycle event pulses from the protocol engine
	typedef struct packed {
		logic default_addr_hit, start_seen, arb_lost_flag;
		logic general_call_hit, own_address_match, stop_seen;
		logic nack_error_flag, rx_byte_flag, tx_done_flag;
	} icc_evt_type;
	// live levels from the protocol engine
	typedef struct packed {
		logic foreign_bus_activity, controller_active, nack_level, dir_level;
	} icc_lvl_type;
endpackage : icc_pkg
`default_nettype wire

// >>> core/icc_glitch_filter.sv
/*
 * Pin synchroniser and glitch suppressor for one bus line.
 * Assumes an asynchronous pin and a filter length from the timing word.
 */
`default_nettype none
module icc_glitch_filter #(
	parameter int unsigned LEN_W = 4
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_pin,
	input wire logic [LEN_W-1:0] i_len,
	output logic o_level
);
	import icc_pkg::*;
	logic s1_q, s2_q, s3_q, lvl_q;
	logic [LEN_W-1:0] cnt_q;
	wire settled = (s2_q == s3_q) && (s3_q != lvl_q);
	wire accept = settled && (cnt_q >= i_len);
	// three stages; a change counts once stages two and three have agreed for i_len + 1 cycles
	always_ff @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			{s1_q, s2_q, s3_q, lvl_q} <= 4'hF;
			cnt_q <= '0;
		end
		else
		begin
			{s1_q, s2_q, s3_q} <= {i_pin, s1_q, s2_q};
			lvl_q <= accept ? s3_q : lvl_q;
			cnt_q <= (settled && !accept) ? cnt_q + 1'b1 : '0;
		end
	end
	assign o_level = lvl_q;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	property p_glitch_hold;
		!$stable(lvl_q) |-> $past(cnt_q) >= $past(i_len);
	endproperty
	a_glitch_hold: assert property (p_glitch_hold) else $error("filter passed a short pulse");
endmodule : icc_glitch_filter
`default_nettype wire

// >>> core/icc_scl_clkgen.sv
/*
 * Reload down-counter that toggles the serial clock level.
 * Assumes divider and filter length stay stable while running.
 */
`default_nettype none
module icc_scl_clkgen #(
	parameter int unsigned DIV_W = 18,
	parameter int unsigned LEN_W = 4
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_run,
	input wire logic [DIV_W-1:0] i_div,
	input wire logic [LEN_W-1:0] i_len,
	output logic o_scl,
	output logic o_toggle
);
	import icc_pkg::*;
	logic [DIV_W-1:0] cnt_q, cnt_d;
	logic [LEN_W:0] hold_q, hold_d;
	logic scl_q, scl_d;
	// the hold adds the reload cycle, and the filter length on the high half
	always_comb
	begin
		cnt_d = cnt_q;
		hold_d = hold_q;
		scl_d = scl_q;
		if (!i_run)
		begin
			cnt_d = i_div;
			hold_d = '0;
			scl_d = 1'b1;
		end
		else if (hold_q != '0)
			hold_d = hold_q - 1'b1;
		else if (cnt_q == '0)
		begin
			scl_d = !scl_q;
			cnt_d = i_div;
			hold_d = scl_q ? (LEN_W+1)'(1) : {1'b0, i_len} + 1'b1;
		end
		else
			cnt_d = cnt_q - 1'b1;
	end
	always_ff @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			{cnt_q, hold_q, scl_q} <= {{(DIV_W+LEN_W+1){1'b0}}, 1'b1};
		else
			{cnt_q, hold_q, scl_q} <= {cnt_d, hold_d, scl_d};
	end
	assign o_scl = scl_q;
	assign o_toggle = i_run && (hold_q == '0) && (cnt_q == '0);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	property p_count_down;
		i_run && $past(i_run) && $past(hold_q) == '0 && $past(cnt_q) != '0
			|-> cnt_q == $past(cnt_q) - 1'b1;
	endproperty
	a_count_down: assert property (p_count_down) else $error("divider did not count down");
endmodule : icc_scl_clkgen
`default_nettype wire

// >>> core/icc_ctrl_status.sv
/*
 * Control tail, event flag bank and serial clock output of the two-wire
 * bus controller, reached over the APB peripheral bus.
 * Assumes a protocol engine on the same clock delivering event pulses and
 * levels, and an open-drain clock pin resolved outside.
 */
`default_nettype none
module icc_ctrl_status (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [icc_pkg::ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire icc_pkg::icc_evt_type i_evt,
	input wire icc_pkg::icc_lvl_type i_lvl,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_scl_oe_n,
	output logic o_scl_filt,
	output logic o_sda_filt,
	output logic o_serial_clock_out,
	output logic o_scl_toggle,
	output logic o_general_call_enable,
	output logic o_ctrl_enable,
	output logic o_soft_rst,
	output logic o_irq
);
	import icc_pkg::*;

	//--------------------------------------------------------------
	// flag packing
	//--------------------------------------------------------------
	// places each event flag at its status bit
	function automatic logic [31:0] flags_to_word(input icc_evt_type f);
		logic [31:0] w;
		w = '0;
		w[SB_DFLT] = f.default_addr_hit;
		w[SB_START] = f.start_seen;
		w[SB_ARB] = f.arb_lost_flag;
		w[SB_GCALL] = f.general_call_hit;
		w[SB_OWN] = f.own_address_match;
		w[SB_STOP] = f.stop_seen;
		w[SB_NACK] = f.nack_error_flag;
		w[SB_RX] = f.rx_byte_flag;
		w[SB_TX] = f.tx_done_flag;
		return w;
	endfunction : flags_to_word

	// picks the event flags back out of a status word
	function automatic icc_evt_type word_to_flags(input logic [31:0] w);
		icc_evt_type f;
		f.default_addr_hit = w[SB_DFLT];
		f.start_seen = w[SB_START];
		f.arb_lost_flag = w[SB_ARB];
		f.general_call_hit = w[SB_GCALL];
		f.own_address_match = w[SB_OWN];
		f.stop_seen = w[SB_STOP];
		f.nack_error_flag = w[SB_NACK];
		f.rx_byte_flag = w[SB_RX];
		f.tx_done_flag = w[SB_TX];
		return f;
	endfunction : word_to_flags

	//--------------------------------------------------------------
	// state
	//--------------------------------------------------------------
	logic [31:0] ctrl_q, ctrl_d;
	logic [DIV_W-1:0] div_q, div_d;
	logic [GLITCH_W-1:0] glitch_q, glitch_d;
	logic [1:0] rst_cnt_q, rst_cnt_d;
	logic [31:0] prdata_q, prdata_d;
	icc_evt_type flags_q, flags_d;
	icc_evt_type evt_set, clr_mask;
	logic [31:0] lvl_word;
	logic [31:0] rd_mux;
	logic [6:0] cause;

	//--------------------------------------------------------------
	// bus decode
	//--------------------------------------------------------------
	// setup phase captures read data, access phase commits writes
	wire setup_ph = i_psel && !i_penable;
	wire access_ph = i_psel && i_penable;
	wire hit_ctrl = (i_paddr == OFF_CTRL);
	wire hit_stat = (i_paddr == OFF_STAT);
	wire hit_div = (i_paddr == OFF_DIV);
	wire hit_time = (i_paddr == OFF_TIME);
	wire hit_any = hit_ctrl || hit_stat || hit_div || hit_time;
	wire wr_ctrl = access_ph && i_pwrite && hit_ctrl;
	wire wr_div = access_ph && i_pwrite && hit_div;
	wire wr_time = access_ph && i_pwrite && hit_time;
	wire rd_stat_acc = access_ph && !i_pwrite && hit_stat;
	// no wait states; unmapped addresses answer with an error
	assign o_pready = 1'b1;
	assign o_pslverr = access_ph && !hit_any;

	//--------------------------------------------------------------
	// control word and soft reset
	//--------------------------------------------------------------
	wire soft_rst = (rst_cnt_q != 2'h0);
	wire ctl_en = ctrl_q[CB_EN];
	wire scl_drive = ctrl_q[CB_SCL];
	wire general_call_enable = ctrl_q[CB_GC];
	// the reset bit is not stored; it reads back as the running pulse
	assign ctrl_d = wr_ctrl ? (i_pwdata & CTRL_WMASK) : ctrl_q;
	assign div_d = wr_div ? i_pwdata[DIV_W-1:0] : div_q;
	assign glitch_d = wr_time ? i_pwdata[GLITCH_LSB +: GLITCH_W] : glitch_q;
	// a fresh write of one restarts the two-cycle pulse
	assign rst_cnt_d = (wr_ctrl && i_pwdata[CB_RST]) ? 2'(SOFT_RST_CYCLES)
		: (soft_rst ? rst_cnt_q - 2'h1 : 2'h0);

	always_ff @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			ctrl_q <= CTRL_RESET;
			div_q <= DIV_RESET;
			glitch_q <= GLITCH_RESET;
			rst_cnt_q <= 2'h0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			div_q <= div_d;
			glitch_q <= glitch_d;
			rst_cnt_q <= rst_cnt_d;
		end
	end

	//--------------------------------------------------------------
	// event flags
	//--------------------------------------------------------------
	// events count only while enabled and outside the soft reset pulse
	wire evt_ok = ctl_en && !soft_rst;
	assign evt_set.default_addr_hit = evt_ok && i_evt.default_addr_hit;
	assign evt_set.start_seen = evt_ok && i_evt.start_seen;
	assign evt_set.arb_lost_flag = evt_ok && i_evt.arb_lost_flag;
	// general-call hits are flagged only when software allows them
	assign evt_set.general_call_hit = evt_ok && general_call_enable && i_evt.general_call_hit;
	assign evt_set.own_address_match = evt_ok && i_evt.own_address_match;
	assign evt_set.stop_seen = evt_ok && i_evt.stop_seen;
	assign evt_set.nack_error_flag = evt_ok && i_evt.nack_error_flag;
	assign evt_set.rx_byte_flag = evt_ok && i_evt.rx_byte_flag;
	assign evt_set.tx_done_flag = evt_ok && i_evt.tx_done_flag;
	// clear only what the read returned, so a later event is never lost
	assign clr_mask = rd_stat_acc ? word_to_flags(prdata_q) : icc_evt_type'(0);
	// a set in the clearing cycle wins over the clear
	assign flags_d = soft_rst ? icc_evt_type'(0)
		: icc_evt_type'((flags_q & ~clr_mask) | evt_set);

	always_ff @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			flags_q <= icc_evt_type'(0);
		else
			flags_q <= flags_d;
	end

	//--------------------------------------------------------------
	// live status levels
	//--------------------------------------------------------------
	// levels read as zero while the controller is switched off
	always_comb
	begin
		lvl_word = '0;
		lvl_word[SB_FOREIGN] = ctl_en && i_lvl.foreign_bus_activity;
		lvl_word[SB_ACTIVE] = ctl_en && i_lvl.controller_active;
		lvl_word[SB_NACK_LVL] = ctl_en && i_lvl.nack_level;
		lvl_word[SB_DIR] = ctl_en && i_lvl.dir_level;
	end

	//--------------------------------------------------------------
	// read data
	//--------------------------------------------------------------
	// unmapped reads and unused bits return zero; the reset bit returns the pulse
	assign rd_mux = hit_ctrl ? {ctrl_q[31:1], soft_rst}
		: hit_stat ? (flags_to_word(flags_q) | lvl_word)
		: hit_div ? {{(32-DIV_W){1'b0}}, div_q}
		: hit_time ? {{(32-GLITCH_LSB-GLITCH_W){1'b0}}, glitch_q, {GLITCH_LSB{1'b0}}}
		: 32'h0000_0000;
	assign prdata_d = (setup_ph && !i_pwrite) ? rd_mux : prdata_q;

	always_ff @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			prdata_q <= 32'h0000_0000;
		else
			prdata_q <= prdata_d;
	end
	assign o_prdata = prdata_q;

	//--------------------------------------------------------------
	// interrupt qualification
	//--------------------------------------------------------------
	// the three address hits share one enable
	assign cause[6] = flags_q.start_seen && ctrl_q[CB_IE_START];
	assign cause[5] = flags_q.arb_lost_flag && ctrl_q[CB_IE_ARB];
	assign cause[4] = (flags_q.own_address_match || flags_q.general_call_hit
		|| flags_q.default_addr_hit) && ctrl_q[CB_IE_ADDR];
	assign cause[3] = flags_q.stop_seen && ctrl_q[CB_IE_STOP];
	assign cause[2] = flags_q.nack_error_flag && ctrl_q[CB_IE_NACK];
	assign cause[1] = flags_q.rx_byte_flag && ctrl_q[CB_IE_RX];
	assign cause[0] = flags_q.tx_done_flag && ctrl_q[CB_IE_TX];
	assign o_irq = |cause;

	//--------------------------------------------------------------
	// serial clock and pins
	//--------------------------------------------------------------
	// clearing the drive bit puts us in slave mode and frees the line
	wire clk_run = scl_drive && ctl_en && !soft_rst;
	logic scl_level;

	icc_scl_clkgen #(
		.DIV_W(DIV_W),
		.LEN_W(GLITCH_W)
	) u_clkgen (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_run(clk_run),
		.i_div(div_q),
		.i_len(glitch_q),
		.o_scl(scl_level),
		.o_toggle(o_scl_toggle)
	);

	icc_glitch_filter #(
		.LEN_W(GLITCH_W)
	) u_scl_filter (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_pin(i_scl),
		.i_len(glitch_q),
		.o_level(o_scl_filt)
	);

	icc_glitch_filter #(
		.LEN_W(GLITCH_W)
	) u_sda_filter (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_pin(i_sda),
		.i_len(glitch_q),
		.o_level(o_sda_filt)
	);

	// open drain: only ever pull low; enable is active low
	assign o_scl = 1'b0;
	assign o_scl_oe_n = !(clk_run && !scl_level);
	assign o_serial_clock_out = scl_level;
	assign o_general_call_enable = general_call_enable;
	assign o_ctrl_enable = ctl_en;
	assign o_soft_rst = soft_rst;

	//--------------------------------------------------------------
	// checks
	//--------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);

	sequence s_rst_write;
		wr_ctrl && i_pwdata[CB_RST];
	endsequence
	sequence s_rst_pulse;
		soft_rst [*2] ##1 !soft_rst;
	endsequence
	property p_soft_rst;
		s_rst_write |=> s_rst_pulse;
	endproperty
	a_soft_rst: assert property (p_soft_rst) else $error("soft reset not two cycles");

	property p_gc_gate;
		!general_call_enable && !flags_q.general_call_hit && !soft_rst |=> !flags_q.general_call_hit;
	endproperty
	a_gc_gate: assert property (p_gc_gate) else $error("general call flagged while off");

	property p_scl_release;
		!scl_drive |-> o_scl_oe_n;
	endproperty
	a_scl_release: assert property (p_scl_release) else $error("clock pulled without drive");

	property p_off_blocks;
		!ctl_en && !flags_q.start_seen |=> !flags_q.start_seen;
	endproperty
	a_off_blocks: assert property (p_off_blocks) else $error("event taken while off");

	property p_irq_needs_cause;
		o_irq |-> (ctrl_q[CB_IE_START:CB_IE_TX] != 7'h00) && (flags_q != icc_evt_type'(0));
	endproperty
	a_irq_needs_cause: assert property (p_irq_needs_cause) else $error("irq without flag");

	property p_irq_rx;
		flags_q.rx_byte_flag && ctrl_q[CB_IE_RX] |-> o_irq;
	endproperty
	a_irq_rx: assert property (p_irq_rx) else $error("enabled rx flag gave no irq");

	property p_rd_clear;
		rd_stat_acc && o_prdata[SB_STOP] && !i_evt.stop_seen |=> !flags_q.stop_seen;
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("stop flag survived read");

	property p_set_wins;
		rd_stat_acc && evt_ok && i_evt.rx_byte_flag |=> flags_q.rx_byte_flag;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("rx event lost in clear");

	property p_start_set;
		evt_ok && i_evt.start_seen |=> flags_q.start_seen && (o_irq || !ctrl_q[CB_IE_START]);
	endproperty
	a_start_set: assert property (p_start_set) else $error("start flag not set");

	property p_arb_hold;
		flags_q.arb_lost_flag && !rd_stat_acc && !soft_rst |=> flags_q.arb_lost_flag;
	endproperty
	a_arb_hold: assert property (p_arb_hold) else $error("arb flag dropped unread");

	property p_clk_toggle;
		o_scl_toggle |=> o_serial_clock_out != $past(o_serial_clock_out);
	endproperty
	a_clk_toggle: assert property (p_clk_toggle) else $error("clock did not toggle");

	// an accepted default-address, stop or transmit event must land in its own flag on the very next edge
	property p_dflt_set;
		evt_ok && i_evt.default_addr_hit |=> flags_q.default_addr_hit;
	endproperty
	a_dflt_set: assert property (p_dflt_set) else $error("default address flag not set");

	property p_stop_set;
		evt_ok && i_evt.stop_seen |=> flags_q.stop_seen;
	endproperty
	a_stop_set: assert property (p_stop_set) else $error("stop flag not set");

	property p_tx_set;
		evt_ok && i_evt.tx_done_flag |=> flags_q.tx_done_flag;
	endproperty
	a_tx_set: assert property (p_tx_set) else $error("transmit flag not set");

	// the soft reset pulse wipes every pending event
	property p_soft_clear;
		soft_rst |=> flags_q == icc_evt_type'(0);
	endproperty
	a_soft_clear: assert property (p_soft_clear) else $error("flag survived soft reset");

	// a stopped generator parks high and lets the line go
	property p_clk_idle;
		!clk_run |=> o_serial_clock_out && o_scl_oe_n;
	endproperty
	a_clk_idle: assert property (p_clk_idle) else $error("clock not parked high");

	property p_lvl_gate;
		!ctl_en && setup_ph && !i_pwrite && hit_stat |=> o_prdata[SB_FOREIGN:SB_DIR] == 4'h0;
	endproperty
	a_lvl_gate: assert property (p_lvl_gate) else $error("level shown while off");
endmodule : icc_ctrl_status
`default_nettype wire

// >>> verification/icc_bus_partner.sv
/*
 * Far side of the two-wire bus: the pull-ups and one other master that
 * briefly pulls the data line low now and then.
 * Assumes the controller's clock pin enable is active low (open drain).
 */
`default_nettype none
module icc_bus_partner (
	input wire logic i_clk_sys,
	input wire logic i_scl_oe_n,
	input wire logic i_scl,
	output logic o_scl_line,
	output logic o_sda_line
);
	timeunit 1ns;
	timeprecision 1ps;
	//------------------------------------------------------------
	// bus lines
	//------------------------------------------------------------
	logic [3:0] slot_q = 4'h0;
	// a released clock line floats high through its pull-up
	assign o_scl_line = i_scl_oe_n ? 1'b1 : i_scl;
	// other traffic on data, so the filter never sees a frozen line
	assign o_sda_line = (slot_q != 4'h0);
	// free-running slot counter of the other master
	always_ff @(posedge i_clk_sys)
	begin
		slot_q <= slot_q + 4'h1;
	end
endmodule : icc_bus_partner
`default_nettype wire

// >>> verification/testbench.sv
/*
 * Self-checking bench of the control tail, flag bank and clock generator.
 * Assumes the protocol engine is replaced by bench-driven event pulses.
 */
`default_nettype none
module testbench import icc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	icc_evt_type evt = '0;
	icc_lvl_type lvl = '0;
	logic [31:0] prdata;
	logic pready, pslverr, oscl, oe_n, sclk, gce, cen, srst, irq, scl_ln, sda_ln;
	logic tgl, sfilt, dfilt;
	logic [32:0] expq[$];
	logic [32:0] note;
	int errors = 0;
	int total_checks = 0;
	int seed = 32'h46a3_d999;
	int d, l, n, lo, hi, tg, seen;
	always #2.5 clk = ~clk;
	icc_ctrl_status uut (.i_clk_sys(clk), .i_sys_rst(rst), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_evt(evt),
		.i_lvl(lvl), .i_scl(scl_ln), .i_sda(sda_ln), .o_scl(oscl), .o_scl_oe_n(oe_n),
		.o_scl_filt(sfilt), .o_sda_filt(dfilt), .o_serial_clock_out(sclk), .o_scl_toggle(tgl),
		.o_general_call_enable(gce), .o_ctrl_enable(cen), .o_soft_rst(srst),
		.o_irq(irq));
	icc_bus_partner far_side (.i_clk_sys(clk), .i_scl_oe_n(oe_n), .i_scl(oscl),
		.o_scl_line(scl_ln), .o_sda_line(sda_ln));
	//------------------------------------------------------------
	// bus tasks and comparison
	//------------------------------------------------------------
	task automatic chk(input logic [31:0] act, input logic [31:0] exp, input string what);
		total_checks++;
		if (act !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, act, exp);
		end
	endtask : chk
	// setup then access; no wait states, so three edges per transfer
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		addr <= a;
		wdata <= dat;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er);
		expq.push_back({er, e});
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd
	// one event pulse; the flag is there after the edge that sees it
	task automatic pulse(input icc_evt_type e);
		@(posedge clk);
		evt <= e;
		@(posedge clk);
		evt <= '0;
		#1;
	endtask : pulse
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	// read answers are judged at the access edge, oldest note first
	always @(posedge clk)
	begin
		if (psel && pen && !pwr && expq.size() > 0)
		begin
			note = expq.pop_front();
			chk(prdata, note[31:0], "read data");
			chk({31'h0, pslverr}, {31'h0, note[32]}, "slave error");
			chk({31'h0, pready}, 32'h0000_0001, "ready");
		end
	end
	// a hang is cut short well past the expected run length
	initial
	begin
		#100000;
		errors++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		end_of_test();
	end
	//------------------------------------------------------------
	// scenarios
	//------------------------------------------------------------
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(OFF_CTRL, CTRL_RESET, 1'b0);
		rd(OFF_STAT, 32'h0000_0000, 1'b0);
		rd(OFF_DIV, {14'h0, DIV_RESET}, 1'b0);
		rd(8'h20, 32'h0000_0000, 1'b1);
		$display("test reset done");
		lvl <= 4'($random(seed));
		apb(1'b1, OFF_CTRL, 32'h0000_7F02);
		pulse(icc_evt_type'(9'h020));
		rd(OFF_STAT, {28'h0, lvl}, 1'b0);
		chk({31'h0, gce}, 32'h0, "gc enable");
		apb(1'b1, OFF_CTRL, 32'h0000_7F0A);
		#1 chk({30'h0, gce, cen}, 32'h3, "ctrl outputs");
		// every event flag, its interrupt and its clear on read
		for (int i = 0; i < 9; i++)
		begin
			pulse(icc_evt_type'(9'h1 << i));
			chk({31'h0, irq}, 32'h1, "irq set");
			rd(OFF_STAT, (32'h1 << ((i == 8) ? 20 : i + 4)) | {28'h0, lvl}, 1'b0);
			rd(OFF_STAT, {28'h0, lvl}, 1'b0);
			chk({31'h0, irq}, 32'h0, "irq clear");
		end
		apb(1'b1, OFF_CTRL, 32'h0000_000A);
		pulse(icc_evt_type'(9'h080));
		chk({31'h0, irq}, 32'h0, "irq masked");
		rd(OFF_STAT, 32'h0000_0800 | {28'h0, lvl}, 1'b0);
		// an rx event on the clearing edge of a status read must survive it
		fork
			rd(OFF_STAT, {28'h0, lvl}, 1'b0);
			begin
				repeat (2) @(posedge clk);
				evt <= icc_evt_type'(9'h002);
				@(posedge clk);
				evt <= '0;
			end
		join
		rd(OFF_STAT, 32'h0000_0020 | {28'h0, lvl}, 1'b0);
		$display("test flags done");
		pulse(icc_evt_type'(9'h001));
		apb(1'b1, OFF_CTRL, 32'h0000_000B);
		n = 0;
		repeat (5)
		begin
			#1 n += (srst === 1'b1);
			@(posedge clk);
		end
		chk(32'(n), 32'(SOFT_RST_CYCLES), "soft reset length");
		rd(OFF_CTRL, 32'h0000_000A, 1'b0);
		rd(OFF_STAT, {28'h0, lvl}, 1'b0);
		$display("test soft reset done");
		d = 2 + ($random(seed) & 7);
		l = $random(seed) & 15;
		apb(1'b1, OFF_DIV, 32'(d));
		apb(1'b1, OFF_TIME, 32'(l) << GLITCH_LSB);
		rd(OFF_DIV, 32'(d), 1'b0);
		rd(OFF_TIME, 32'(l) << GLITCH_LSB, 1'b0);
		apb(1'b1, OFF_CTRL, 32'h0000_000E);
		n = 0;
		while (sclk !== 1'b0 && n < 5000)
		begin
			@(negedge clk);
			n++;
		end
		chk({31'h0, oe_n}, 32'h0, "clock pin pulled");
		lo = 0;
		tg = 0;
		seen = 0;
		// the filtered pin only follows a low half at least two cycles longer than the filter length
		while (sclk === 1'b0 && lo < 5000)
		begin
			@(negedge clk);
			lo++;
			tg += (tgl === 1'b1);
			seen |= (sfilt === 1'b0);
		end
		hi = 0;
		while (sclk === 1'b1 && hi < 5000)
		begin
			@(negedge clk);
			hi++;
			tg += (tgl === 1'b1);
			seen |= (sfilt === 1'b0);
		end
		chk(32'(lo), 32'(d + 2), "low half");
		chk(32'(hi), 32'(d + 2 + l), "high half");
		chk(32'(tg), 32'h0000_0002, "toggle pulses");
		chk(32'(seen), 32'(l <= d), "clock pin filtered");
		apb(1'b1, OFF_CTRL, 32'h0000_000A);
		repeat (3 * d + 40) @(posedge clk);
		#1 chk({28'h0, sfilt, oscl, sclk, oe_n}, 32'h0000_000B, "clock idle");
		chk({31'h0, dfilt}, 32'h0000_0001, "data glitch suppressed");
		$display("test clock done");
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
